/* File: hw/serial_link_rx_status_regs.sv */
// Our own choice: the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// - Dense packing flag reads constant one.
// - Five-bit control bits per sample, link zero.
// - Spare, checksum and status fields banked, chosen by link page; link page and threshold shared.
// - Two spare read/write bytes, reset zero.
// - Read/write configuration checksum byte, reset zero.
// - Per-lane alignment status byte, one means aligned.
// - Disparity error bit set when count reaches threshold.
// - Invalid code bit set when count reaches threshold.
module serial_link_rx_status_regs
   import rx_status_pkg::*;
#(
   parameter int NUM_LINKS = 2,
   parameter int CNT_W     = 8
) (
   input  wire logic                       clk_sys,
   input  wire logic                       reset,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [15:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic                            pready,
   output logic      [31:0]                prdata,
   output logic                            pslverr,
   input  wire logic [CTRL_BITS_W-1:0]     ctrl_bits_per_sample,
   input  wire logic [NUM_LINKS*LANES-1:0] lane_align_ok,
   input  wire logic [NUM_LINKS*LANES-1:0] lane_disp_err_evt,
   input  wire logic [NUM_LINKS*LANES-1:0] lane_bad_code_evt
);

   localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_SETUP  = 2'b01,
      BUS_ACCESS = 2'b10
   } bus_phase_t;

   bus_phase_t                 phase;
   logic                       setup_cyc;
   logic                       access_cyc;
   logic                       wr_take;
   logic                       hit;
   logic [31:0]                rd_word;

   logic [7:0]                 link_page_q;
   logic [PAGE_W-1:0]          page_sel;
   logic [CNT_W-1:0]           threshold_q;
   logic [NUM_LINKS-1:0]       clr_link;

   logic [CTRL_BITS_W-1:0]     ctrl_bits_q;
   logic [NUM_LINKS*LANES-1:0] align_q;
   logic [NUM_LINKS*LANES-1:0] disp_flags;
   logic [NUM_LINKS*LANES-1:0] bad_code_flags;

   logic                       wr_spare_one;
   logic                       wr_spare_two;
   logic                       wr_checksum;
   logic [7:0]                 spare_one_rd;
   logic [7:0]                 spare_two_rd;
   logic [7:0]                 checksum_rd;
   logic [7:0]                 align_rd;
   logic [7:0]                 disp_rd;
   logic [7:0]                 bad_code_rd;
   logic [7:0]                 density_rd;

   logic [31:0]                prdata_q;
   logic                       pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus phase. Read data is captured in the setup cycle so that the answer
   // comes from a flip-flop; pready is still high in the first access cycle, with no wait state.
   assign setup_cyc  = psel && !penable;
   assign access_cyc = psel && penable;
   assign wr_take    = access_cyc && pwrite;

   always_comb begin
      if (setup_cyc) begin
         phase = BUS_SETUP;
      end else if (access_cyc) begin
         phase = BUS_ACCESS;
      end else begin
         phase = BUS_IDLE;
      end
   end

   assign pready  = (phase == BUS_ACCESS);
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q && pready;

   ////////////////////////////////////////////////////////////////////////////
   // Page select. Page values beyond the number of links fold onto the low
   // bits, so software must keep the page below the link count.
   assign page_sel = link_page_q[PAGE_W-1:0];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link_page_q <= LINK_PAGE_RESET;
      end else if (wr_take && (paddr == ADDR_LINK_PAGE)) begin
         link_page_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         threshold_q <= CNT_W'(THRESHOLD_RESET);
      end else if (wr_take && (paddr == ADDR_ERR_THRESHOLD)) begin
         threshold_q <= pwdata[CNT_W-1:0];
      end
   end

   // Writing one to bit 0 of the clear register restarts the counters of the
   // selected link for one cycle; an error in that same cycle still counts.
   always_comb begin
      clr_link = '0;
      if (wr_take && (paddr == ADDR_ERR_CLEAR) && pwdata[0]) begin
         clr_link[page_sel] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link-side status capture.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_bits_q <= CTRL_BITS_RESET;
      end else begin
         ctrl_bits_q <= ctrl_bits_per_sample;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         align_q <= '0;
      end else begin
         align_q <= lane_align_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error counters, one for each lane, link and error kind.
   for (genvar i = 0; i < NUM_LINKS*LANES; i++) begin : g_lane
      lane_evt_if #(.CNT_W(CNT_W)) disp_if ();
      lane_evt_if #(.CNT_W(CNT_W)) code_if ();

      assign disp_if.evt   = lane_disp_err_evt[i];
      assign disp_if.clr   = clr_link[i/LANES];
      assign disp_if.thr   = threshold_q;
      assign disp_flags[i] = disp_if.flag;

      assign code_if.evt       = lane_bad_code_evt[i];
      assign code_if.clr       = clr_link[i/LANES];
      assign code_if.thr       = threshold_q;
      assign bad_code_flags[i] = code_if.flag;

      lane_err_counter #(.CNT_W(CNT_W)) u_disp_cnt (
         .clk_sys (clk_sys),
         .reset   (reset),
         .lane    (disp_if)
      );

      lane_err_counter #(.CNT_W(CNT_W)) u_code_cnt (
         .clk_sys (clk_sys),
         .reset   (reset),
         .lane    (code_if)
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Banked read/write bytes.
   assign wr_spare_one = wr_take && (paddr == ADDR_SPARE_ONE);
   assign wr_spare_two = wr_take && (paddr == ADDR_SPARE_TWO);
   // The checksum is accepted at any time; holding the core in soft reset
   // while it changes is left to software.
   assign wr_checksum  = wr_take && (paddr == ADDR_CHECKSUM);

   banked_byte_reg #(
      .NUM_LINKS (NUM_LINKS),
      .PAGE_W    (PAGE_W),
      .RESET_VAL (SPARE_RESET)
   ) u_spare_one (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wr_en   (wr_spare_one),
      .page    (page_sel),
      .wr_data (pwdata[7:0]),
      .rd_data (spare_one_rd)
   );

   banked_byte_reg #(
      .NUM_LINKS (NUM_LINKS),
      .PAGE_W    (PAGE_W),
      .RESET_VAL (SPARE_RESET)
   ) u_spare_two (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wr_en   (wr_spare_two),
      .page    (page_sel),
      .wr_data (pwdata[7:0]),
      .rd_data (spare_two_rd)
   );

   banked_byte_reg #(
      .NUM_LINKS (NUM_LINKS),
      .PAGE_W    (PAGE_W),
      .RESET_VAL (CHECKSUM_RESET)
   ) u_checksum (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wr_en   (wr_checksum),
      .page    (page_sel),
      .wr_data (pwdata[7:0]),
      .rd_data (checksum_rd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Paged read views of the status bytes.
   always_comb begin
      density_rd                 = 8'h00;
      density_rd[DENSE_FLAG_BIT] = DENSE_FLAG_VALUE;
      if (page_sel == PAGE_W'(0)) begin
         density_rd[CTRL_BITS_W-1:0] = ctrl_bits_q;
      end
   end

   assign align_rd    = align_q[page_sel*LANES +: LANES];
   assign disp_rd     = disp_flags[page_sel*LANES +: LANES];
   assign bad_code_rd = bad_code_flags[page_sel*LANES +: LANES];

   ////////////////////////////////////////////////////////////////////////////
   // Address decode for reads. Unmapped addresses read zero with an error.
   always_comb begin
      rd_word = 32'h0000_0000;
      hit     = 1'b1;
      if (paddr == ADDR_LINK_PAGE) begin
         rd_word[7:0] = link_page_q;
      end else if (paddr == ADDR_DENSITY_CTRL) begin
         rd_word[7:0] = density_rd;
      end else if (paddr == ADDR_SPARE_ONE) begin
         rd_word[7:0] = spare_one_rd;
      end else if (paddr == ADDR_SPARE_TWO) begin
         rd_word[7:0] = spare_two_rd;
      end else if (paddr == ADDR_CHECKSUM) begin
         rd_word[7:0] = checksum_rd;
      end else if (paddr == ADDR_ALIGN_STATUS) begin
         rd_word[7:0] = align_rd;
      end else if (paddr == ADDR_DISP_STATUS) begin
         rd_word[7:0] = disp_rd;
      end else if (paddr == ADDR_BAD_CODE) begin
         rd_word[7:0] = bad_code_rd;
      end else if (paddr == ADDR_ERR_THRESHOLD) begin
         rd_word[CNT_W-1:0] = threshold_q;
      end else if (paddr == ADDR_ERR_CLEAR) begin
         rd_word = 32'h0000_0000;
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_cyc) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pslverr_q <= 1'b0;
      end else if (setup_cyc) begin
         pslverr_q <= !hit;
      end
   end

endmodule // serial_link_rx_status_regs

/* File: hw/rx_status_pkg.sv */
package rx_status_pkg;

   // Register indices. The byte address on the bus is four times the index.
   localparam logic [11:0] IDX_LINK_PAGE      = 12'h300;
   localparam logic [11:0] IDX_DENSITY_CTRL   = 12'h45A;
   localparam logic [11:0] IDX_SPARE_ONE      = 12'h45B;
   localparam logic [11:0] IDX_SPARE_TWO      = 12'h45C;
   localparam logic [11:0] IDX_CHECKSUM       = 12'h45D;
   localparam logic [11:0] IDX_ALIGN_STATUS   = 12'h46C;
   localparam logic [11:0] IDX_DISP_STATUS    = 12'h46D;
   localparam logic [11:0] IDX_BAD_CODE       = 12'h46E;
   localparam logic [11:0] IDX_ERR_THRESHOLD  = 12'h470;
   localparam logic [11:0] IDX_ERR_CLEAR      = 12'h471;

   localparam logic [15:0] ADDR_LINK_PAGE     = {2'h0, IDX_LINK_PAGE, 2'h0};
   localparam logic [15:0] ADDR_DENSITY_CTRL  = {2'h0, IDX_DENSITY_CTRL, 2'h0};
   localparam logic [15:0] ADDR_SPARE_ONE     = {2'h0, IDX_SPARE_ONE, 2'h0};
   localparam logic [15:0] ADDR_SPARE_TWO     = {2'h0, IDX_SPARE_TWO, 2'h0};
   localparam logic [15:0] ADDR_CHECKSUM      = {2'h0, IDX_CHECKSUM, 2'h0};
   localparam logic [15:0] ADDR_ALIGN_STATUS  = {2'h0, IDX_ALIGN_STATUS, 2'h0};
   localparam logic [15:0] ADDR_DISP_STATUS   = {2'h0, IDX_DISP_STATUS, 2'h0};
   localparam logic [15:0] ADDR_BAD_CODE      = {2'h0, IDX_BAD_CODE, 2'h0};
   localparam logic [15:0] ADDR_ERR_THRESHOLD = {2'h0, IDX_ERR_THRESHOLD, 2'h0};
   localparam logic [15:0] ADDR_ERR_CLEAR     = {2'h0, IDX_ERR_CLEAR, 2'h0};

   // Field positions and reset values.
   localparam int          DENSE_FLAG_BIT     = 7;
   localparam logic        DENSE_FLAG_VALUE   = 1'h1;
   localparam int          CTRL_BITS_W        = 5;
   localparam logic [4:0]  CTRL_BITS_RESET    = 5'h00;
   localparam logic [7:0]  SPARE_RESET        = 8'h00;
   localparam logic [7:0]  CHECKSUM_RESET     = 8'h00;
   localparam logic [7:0]  STATUS_RESET       = 8'h00;
   localparam logic [7:0]  LINK_PAGE_RESET    = 8'h00;
   localparam logic [7:0]  THRESHOLD_RESET    = 8'hFF;
   localparam int          LANES              = 8;

endpackage

/* File: hw/lane_evt_if.sv */
`timescale 1ns/100ps
interface lane_evt_if #(
   parameter int CNT_W = 8
);
   logic             evt;
   logic             clr;
   logic [CNT_W-1:0] thr;
   logic [CNT_W-1:0] count;
   logic             flag;

   modport counter (input evt, input clr, input thr, output count, output flag);
   modport ctrl    (output evt, output clr, output thr, input count, input flag);
endinterface

/* File: hw/lane_err_counter.sv */
`timescale 1ns/100ps
module lane_err_counter
   import rx_status_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   lane_evt_if.counter     lane
);

   localparam logic [CNT_W-1:0] CNT_MAX  = '1;
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   logic [CNT_W-1:0] count_q;
   logic             flag_q;

   ////////////////////////////////////////////////////////////////////////////
   // Saturating so that a flood of errors never wraps back below threshold.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_q <= CNT_ZERO;
      end else if (lane.clr) begin
         count_q <= lane.evt ? CNT_ONE : CNT_ZERO;
      end else if (lane.evt && (count_q != CNT_MAX)) begin
         count_q <= count_q + CNT_ONE;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= (count_q >= lane.thr);
      end
   end

   assign lane.count = count_q;
   assign lane.flag  = flag_q;

endmodule // lane_err_counter

/* File: hw/banked_byte_reg.sv */
`timescale 1ns/100ps
module banked_byte_reg
   import rx_status_pkg::*;
#(
   parameter int         NUM_LINKS = 2,
   parameter int         PAGE_W    = 1,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              wr_en,
   input  wire logic [PAGE_W-1:0] page,
   input  wire logic [7:0]        wr_data,
   output logic      [7:0]        rd_data
);

   logic [7:0] bank_q [NUM_LINKS];

   ////////////////////////////////////////////////////////////////////////////
   for (genvar l = 0; l < NUM_LINKS; l++) begin : g_bank
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            bank_q[l] <= RESET_VAL;
         end else if (wr_en && (page == PAGE_W'(l))) begin
            bank_q[l] <= wr_data;
         end
      end
   end

   assign rd_data = bank_q[page];

endmodule // banked_byte_reg

/* File: sim/link_tx_model.sv */
`timescale 1ns/100ps
module link_tx_model #(
   parameter int W = 16
) (
   input  wire logic         clk_sys,
   output logic      [W-1:0] align_ok,
   output logic      [W-1:0] disp_evt,
   output logic      [W-1:0] bad_evt,
   output logic      [4:0]   ctrl_bits
);
   initial begin
      align_ok = '0;
      disp_evt = '0;
      bad_evt = '0;
      ctrl_bits = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Each high cycle is one error, so a burst holds the mask for n edges.
   task send(input logic [W-1:0] dm, input logic [W-1:0] bm, input int n);
      @(posedge clk_sys);
      disp_evt <= dm;
      bad_evt <= bm;
      repeat (n - 1) @(posedge clk_sys);
      @(posedge clk_sys);
      disp_evt <= '0;
      bad_evt <= '0;
   endtask
   task drive(input logic [W-1:0] al, input logic [4:0] cb);
      @(posedge clk_sys);
      align_ok <= al;
      ctrl_bits <= cb;
   endtask
endmodule // link_tx_model

/* File: sim/rx_status_checker.sv */
`timescale 1ns/100ps
module rx_status_checker
   import rx_status_pkg::*;
#(
   parameter int NUM_LINKS = 2,
   parameter int CNT_W     = 8
) (
   input wire logic                       clk_sys,
   input wire logic                       reset,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [15:0]                paddr,
   input wire logic [31:0]                pwdata,
   input wire logic                       pready,
   input wire logic [31:0]                prdata,
   input wire logic                       pslverr,
   input wire logic [CTRL_BITS_W-1:0]     ctrl_bits_per_sample,
   input wire logic [NUM_LINKS*LANES-1:0] lane_align_ok,
   input wire logic [NUM_LINKS*LANES-1:0] lane_disp_err_evt,
   input wire logic [NUM_LINKS*LANES-1:0] lane_bad_code_evt
);
   logic       page_q;
   logic       quiet_q;
   logic [7:0] align_pg;
   assign align_pg = lane_align_ok[page_q*LANES +: LANES];
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         page_q <= 1'b0;
      end else if (psel && penable && pwrite && paddr == ADDR_LINK_PAGE) begin
         page_q <= pwdata[0];
      end
   end
   // Status may only be assumed clear while no error has arrived and no zero threshold has been written since reset.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         quiet_q <= 1'b1;
      end else if ((|lane_disp_err_evt) || (|lane_bad_code_evt)) begin
         quiet_q <= 1'b0;
      end else if (psel && penable && pwrite && paddr == ADDR_ERR_THRESHOLD
                   && pwdata[7:0] == 8'h00) begin
         quiet_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_rd(logic [15:0] a);
      psel && !penable && !pwrite && paddr == a ##1 psel && penable;
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   a_ready_access: assert property (pready == (psel && penable))
      else $error("pready does not follow the access phase");
   a_setup_answer: assert property (s_setup |=> pready)
      else $error("no answer in first access cycle");
   a_dense_flag: assert property (s_rd(ADDR_DENSITY_CTRL) |-> prdata[31:5] == 27'h4)
      else $error("density byte upper bits wrong");
   a_ctrl_link_zero: assert property (s_rd(ADDR_DENSITY_CTRL) ##0 !page_q
      && $past(ctrl_bits_per_sample, 1) == $past(ctrl_bits_per_sample, 3)
      && $past(ctrl_bits_per_sample, 2) == $past(ctrl_bits_per_sample, 3)
      |-> prdata[4:0] == $past(ctrl_bits_per_sample, 1))
      else $error("control bits per sample wrong on link zero");
   a_ctrl_other_link: assert property (s_rd(ADDR_DENSITY_CTRL) ##0 page_q
      |-> prdata[4:0] == 5'h00)
      else $error("control bits not zero on other link");
   a_align_paged: assert property (s_rd(ADDR_ALIGN_STATUS)
      ##0 $past(align_pg, 1) == $past(align_pg, 3)
      && $past(align_pg, 2) == $past(align_pg, 3) |-> prdata == {24'h0, $past(align_pg, 1)})
      else $error("alignment byte does not match paged lanes");
   a_disp_quiet: assert property (s_rd(ADDR_DISP_STATUS) ##0 quiet_q |-> prdata == 32'h0)
      else $error("disparity status set with no errors");
   a_code_quiet: assert property (s_rd(ADDR_BAD_CODE) ##0 quiet_q |-> prdata == 32'h0)
      else $error("invalid code status set with no errors");
   a_unmapped_err: assert property (psel && penable && paddr == 16'h0000
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
endmodule // rx_status_checker
bind serial_link_rx_status_regs rx_status_checker #(.NUM_LINKS(NUM_LINKS), .CNT_W(CNT_W)) u_chk (
   .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .ctrl_bits_per_sample(ctrl_bits_per_sample), .lane_align_ok(lane_align_ok),
   .lane_disp_err_evt(lane_disp_err_evt), .lane_bad_code_evt(lane_bad_code_evt));

/* File: sim/test_serial_link_rx_status_regs.sv */
`timescale 1ns/100ps
module test_serial_link_rx_status_regs;
   import rx_status_pkg::*;
   logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   wire  [15:0] align_ok, disp_evt, bad_evt;
   wire  [4:0]  ctrl_bits;
   int          n_fail, samples_checked;
   logic [15:0] zero_addr [6] = '{ADDR_SPARE_ONE, ADDR_SPARE_TWO, ADDR_CHECKSUM,
                                  ADDR_ALIGN_STATUS, ADDR_DISP_STATUS, ADDR_BAD_CODE};
   logic [7:0]  wv [2][3] = '{'{8'h5A, 8'hC3, 8'h7E}, '{8'hA5, 8'h3C, 8'h81}};
   serial_link_rx_status_regs DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ctrl_bits_per_sample(ctrl_bits),
      .lane_align_ok(align_ok), .lane_disp_err_evt(disp_evt), .lane_bad_code_evt(bad_evt));
   link_tx_model u_tx (.clk_sys(clk_sys), .align_ok(align_ok), .disp_evt(disp_evt),
      .bad_evt(bad_evt), .ctrl_bits(ctrl_bits));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The master never assumes a latency; only the watchdog ends a stuck wait.
   task apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [15:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(rd, {24'h0, e});
   endtask
   task results;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #20000;
      n_fail++;
      results();
   end
   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      for (int l = 0; l < 2; l++) begin
         apb(1'b1, ADDR_LINK_PAGE, l[7:0]);
         rdc(ADDR_DENSITY_CTRL, 8'h80);
         for (int i = 0; i < 6; i++) begin
            rdc(zero_addr[i], 8'h00);
         end
      end
      u_tx.drive(16'hA53C, 5'h15);
      repeat (3) @(posedge clk_sys);
      rdc(ADDR_DENSITY_CTRL, 8'h80);
      rdc(ADDR_ALIGN_STATUS, 8'hA5);
      apb(1'b1, ADDR_LINK_PAGE, 8'h00);
      rdc(ADDR_DENSITY_CTRL, 8'h95);
      rdc(ADDR_ALIGN_STATUS, 8'h3C);
      // Checksum is written during setup only, before any error traffic.
      for (int l = 0; l < 2; l++) begin
         apb(1'b1, ADDR_LINK_PAGE, l[7:0]);
         for (int i = 0; i < 3; i++) apb(1'b1, zero_addr[i], wv[l][i]);
      end
      apb(1'b1, ADDR_DENSITY_CTRL, 8'h00);
      rdc(ADDR_DENSITY_CTRL, 8'h80);
      for (int l = 1; l >= 0; l--) begin
         apb(1'b1, ADDR_LINK_PAGE, l[7:0]);
         for (int i = 0; i < 3; i++) rdc(zero_addr[i], wv[l][i]);
      end
      apb(1'b1, 16'h0000, 8'hFF);
      apb(1'b0, 16'h0000, 8'h00);
      check({rd[31:1], err}, 32'h1);
      apb(1'b1, ADDR_ERR_THRESHOLD, 8'h03);
      u_tx.send(16'h0004, 16'h0000, 2);
      repeat (2) @(posedge clk_sys);
      rdc(ADDR_DISP_STATUS, 8'h00);
      u_tx.send(16'h0004, 16'h0000, 1);
      repeat (2) @(posedge clk_sys);
      rdc(ADDR_DISP_STATUS, 8'h04);
      rdc(ADDR_BAD_CODE, 8'h00);
      u_tx.send(16'h0000, 16'h8000, 3);
      repeat (2) @(posedge clk_sys);
      rdc(ADDR_BAD_CODE, 8'h00);
      apb(1'b1, ADDR_LINK_PAGE, 8'h01);
      rdc(ADDR_BAD_CODE, 8'h80);
      rdc(ADDR_DISP_STATUS, 8'h00);
      apb(1'b1, ADDR_ERR_CLEAR, 8'h01);
      rdc(ADDR_BAD_CODE, 8'h00);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rdc(ADDR_SPARE_ONE, 8'h00);
      rdc(ADDR_CHECKSUM, 8'h00);
      results();
   end
endmodule // test_serial_link_rx_status_regs
